// ---- testbench/ddswp_dac_model.sv ----
// behavioural converter and digital line model at the far side of the path
`timescale 1ns/10ps
`default_nettype none
module ddswp_dac_model
    import ddswp_pkg::*;
(
    // clock
    input wire logic clk_i,
    // converter side
    input wire logic strobe_i,
    input wire logic [ddswp_pkg::DAC_W-1:0] dac_i,
    // digital lines
    input wire logic [ddswp_pkg::SAMP_W-1:0] dig_i,
    input wire logic [ddswp_pkg::SAMP_W-1:0] oe_i,
    // observation
    output logic [31:0] conv_o,
    output logic [ddswp_pkg::DAC_W-1:0] code_o,
    output logic [ddswp_pkg::SAMP_W-1:0] line_o
);
    logic [SAMP_W-1:0] last = '0; // last level seen on each line
    initial conv_o = 32'h0;
    // one conversion per strobe, top twelve bits only
    always @(posedge clk_i) begin
        if (strobe_i) begin
            conv_o <= conv_o + 32'h1;
            code_o <= dac_i;
        end
        last <= line_o;
    end
    // undriven lines float: show the inverse of the last level, so they toggle every clock
    assign line_o = (oe_i & dig_i) | (~oe_i & ~last);
endmodule // ddswp_dac_model
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench of the dds lookup waveform path
`timescale 1ns/10ps
`default_nettype none
module tb;
    import ddswp_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [ACC_W-1:0] inc = '0;
    logic vmode = 1'b0, f525 = 1'b0, ins = 1'b0, wr_en = 1'b0, vval = 1'b0, full = 1'b0;
    ddswp_sync_type sync = '0;
    ddswp_wr_type wr = '0;
    logic [SAMP_W-1:0] vdat = '0, lastv = '0, base;
    logic vrdy, strobe, lstart, act;
    logic [DAC_W-1:0] dac;
    logic [SAMP_W-1:0] dig, oe, line;
    logic [31:0] conv;
    int n_fail = 0, n_compared = 0, cyc = 0, mon = 0, lc = 0, ac = 0, nl = 0;
    integer seed = 32'h110d;
    logic [SAMP_W-1:0] lut [DEPTH]; // reference copy of the table
    logic [27:0] got [$];
    logic [SAMP_W-1:0] vq [$];
    always #20 clk_i = ~clk_i;
    ddswp_top ddswp_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .phase_increment_word_i(inc),
        .mode_video_i(vmode), .format_525_i(f525), .digital_sync_insert_i(ins), .sync_i(sync),
        .wr_en_i(wr_en), .wr_i(wr), .vid_valid_i(vval), .vid_ready_o(vrdy), .vid_data_i(vdat),
        .dac_data_o(dac), .dig_data_o(dig), .dig_oe_o(oe), .sample_strobe_o(strobe),
        .line_start_o(lstart), .active_o(act));
    ddswp_dac_model ddswp_dac_model_inst (.clk_i(clk_i), .strobe_i(strobe), .dac_i(dac),
        .dig_i(dig), .oe_i(oe), .conv_o(conv), .code_o(), .line_o(line));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // monitor: pre-edge samples, so no race with the drivers
    always @(posedge clk_i) begin
        cyc++;
        if (cyc > 45000) begin
            n_fail++;
            tally_and_finish();
        end
        if (mon == 1) begin
            chk(strobe, 1'b1);
            got.push_back({dac, dig});
            if (ins) chk(line, dig);
        end
        if (mon == 2) begin
            if (!vrdy) full = 1'b1;
            if (strobe && vq.size() > 0) chk(dig, vq.pop_front());
            if (vval && vrdy) begin
                vq.push_back(vdat);
                lastv = vdat;
                vdat <= SAMP_W'($random(seed));
            end
            if (lstart) begin
                if (nl > 0) chk(lc, f525 ? LINE_525 : LINE_OTHER);
                if (nl > 0) chk(ac, f525 ? ACTIVE_525 : ACTIVE_OTHER);
                nl++;
                lc = 0;
                ac = 0;
            end
            if (strobe) begin
                lc++;
                ac += act;
            end
        end
    end
    task automatic rst(input int m);
        mon <= 0;
        rst_n_i <= 1'b0;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        mon <= m;
    endtask
    // function mode: the stream is the table read at multiples of the word
    task automatic frun(input logic [31:0] w, input logic si);
        int k0, k, bad;
        logic [31:0] ph;
        logic [15:0] e;
        inc <= w;
        ins <= si;
        sync <= 4'($random(seed));
        vmode <= 1'b0;
        got.delete();
        rst(0);
        repeat (4) @(posedge clk_i);
        mon <= 1;
        repeat (48) @(posedge clk_i);
        mon <= 0;
        @(posedge clk_i);
        for (k0 = 0; k0 < 12; k0++) begin
            bad = 0;
            for (k = 0; k < 48; k++) begin
                ph = w * (k0 + k);
                if (got[k][15:4] !== lut[ph[31:18]][15:4]) bad++;
            end
            if (bad == 0) break;
        end
        for (k = 0; k < 48; k++) begin
            ph = w * (k0 + k);
            e = lut[ph[31:18]];
            if (si) e = {e[15:4], sync};
            chk(got[k], {e[15:4], e});
        end
        chk(oe, {16{si}});
        $display("function test done word %h", w);
    endtask
    // video playback: order, rate, line timing, fill and underflow
    task automatic vrun(input logic fmt);
        logic [31:0] c0, d, e;
        inc <= $random(seed);
        vmode <= 1'b1;
        f525 <= fmt;
        ins <= 1'b0;
        full = 1'b0;
        nl = 0;
        vq.delete();
        rst(2);
        vval <= 1'b1;
        c0 = conv;
        repeat (8000) @(posedge clk_i);
        d = conv - c0;
        e = 32'((64'd8000 * (fmt ? STEP_525 : STEP_OTHER)) >> 32);
        chk((d > e ? d - e : e - d) <= 1, 1'b1);
        chk(full, 1'b1);
        chk(nl >= 2, 1'b1);
        vval <= 1'b0;
        repeat (64) @(posedge clk_i);
        chk(dig, lastv);
        chk(vrdy, 1'b1);
        mon <= 0;
        $display("video test done format %0d", fmt);
    endtask
    initial begin
        base = SAMP_W'($random(seed));
        rst(0);
        // table holds one cycle of distinct words over every entry
        for (int i = 0; i < DEPTH; i++) begin
            lut[i] = base + SAMP_W'(i * 5);
            wr_en <= 1'b1;
            wr <= '{addr: ADDR_W'(i), data: lut[i]};
            @(posedge clk_i);
        end
        wr_en <= 1'b0;
        frun(FULL_SWEEP_WORD, 1'b0);
        frun(32'h0002_0000, 1'b1);
        frun($random(seed), 1'b0);
        frun($random(seed) | 32'h8000_0000, 1'b1);
        vrun(1'b1);
        vrun(1'b0);
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire

// ---- verilog/ddswp_fifo.sv ----
// parameterised valid/ready fifo for playback samples
`timescale 1ns/10ps
`default_nettype none
module ddswp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];   // storage
    logic [AW:0] wr_ptr, rd_ptr;     // extra bit tells full from empty
    logic [AW:0] next_wr_ptr, next_rd_ptr;
    logic full, empty, push, pop;
    // ----------------------------------------
    // pointer arithmetic
    // ----------------------------------------
    always_comb begin
        empty = (wr_ptr == rd_ptr);
        full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
        push = in_valid_i && !full;
        pop = out_valid_o && out_ready_i;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    end
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[rd_ptr[AW-1:0]];
    // registers only
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end
    // never push past full
    fifo_no_overrun_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        full |=> wr_ptr == $past(wr_ptr))
        else $error("fifo pointer moved while full");
endmodule // ddswp_fifo
`default_nettype wire

// ---- verilog/ddswp_pkg.sv ----
// package: constants and carrier types of the dds lookup waveform path
package ddswp_pkg;
    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int ACC_W = 32;      // phase accumulator width
    localparam int ADDR_W = 14;     // lookup address width
    localparam int DEPTH = 16384;   // lookup entries
    localparam int SAMP_W = 16;     // stored sample width
    localparam int DAC_W = 12;      // converter width
    localparam int FLAG_W = 4;      // sync flag field width
    localparam int FIFO_DEPTH = 16; // playback fifo depth
    // ----------------------------------------
    // rates and line timing
    // ----------------------------------------
    localparam int SAMPLE_CLK_HZ = 40000000;             // function mode sample clock
    localparam int RATE_525_HZ = 20013986;               // 525-line playback rate
    localparam int RATE_OTHER_HZ = 20000000;             // other formats playback rate
    localparam logic [10:0] LINE_525 = 11'h4F8;          // 1272 samples per line
    localparam logic [10:0] ACTIVE_525 = 11'h414;        // 1044 active samples
    localparam logic [10:0] LINE_OTHER = 11'h500;        // 1280 samples per line
    localparam logic [10:0] ACTIVE_OTHER = 11'h410;      // 1040 active samples
    // phase steps per sample clock for each playback rate (rate * 2^32 / clock)
    localparam logic [ACC_W-1:0] STEP_525 = 32'h8016_E8F2;
    localparam logic [ACC_W-1:0] STEP_OTHER = 32'h8000_0000;
    // increment that visits every entry once per clock: 2^(32-14)
    localparam logic [ACC_W-1:0] FULL_SWEEP_WORD = 32'h0004_0000;
    localparam logic [ACC_W-1:0] ACC_RESET = 32'h0000_0000;
    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic vsync;
        logic hsync;
        logic csync;
        logic field_parity_bit;
    } ddswp_sync_type;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [SAMP_W-1:0] data;
    } ddswp_wr_type;
    typedef enum logic [0:0] {
        MODE_FUNC = 1'b0,
        MODE_VIDEO = 1'b1
    } ddswp_mode_type;
endpackage : ddswp_pkg

// ---- verilog/ddswp_top.sv ----
// dds lookup waveform path: accumulator, lookup memory, video playback, sync insertion
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - lookup memory holds 16384 sixteen-bit samples
// - accumulator runs on the 40 MHz clock
// - phase accumulator is 32 bits wide
// - increment word added every clock
// - upper 14 accumulator bits address lookup
// - word 262144 steps one entry per clock
// - function mode: one sample every clock, skipping entries
// - sync flags replace the four low bits
// - sync insertion also enables digital lines
// - 525-line: 20.013986 MHz, 1272/1044 samples
// - others: 20 MHz, 1280/1040 samples
module ddswp_top
    import ddswp_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic [ddswp_pkg::ACC_W-1:0] phase_increment_word_i,
    input wire logic mode_video_i,
    input wire logic format_525_i,
    input wire logic digital_sync_insert_i,
    input wire ddswp_pkg::ddswp_sync_type sync_i,
    // lookup memory load port
    input wire logic wr_en_i,
    input wire ddswp_pkg::ddswp_wr_type wr_i,
    // video playback stream in
    input wire logic vid_valid_i,
    output logic vid_ready_o,
    input wire logic [ddswp_pkg::SAMP_W-1:0] vid_data_i,
    // converter and digital lines
    output logic [ddswp_pkg::DAC_W-1:0] dac_data_o,
    output logic [ddswp_pkg::SAMP_W-1:0] dig_data_o,
    output logic [ddswp_pkg::SAMP_W-1:0] dig_oe_o,
    output logic sample_strobe_o,
    output logic line_start_o,
    output logic active_o
);
    import ddswp_pkg::*;
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [ACC_W-1:0] phase, next_phase;       // dds accumulator
    logic [ACC_W-1:0] play_phase, next_play_phase; // playback rate divider
    logic [10:0] line_cnt, next_line_cnt;      // position within video line
    logic play_en;                             // one-cycle playback enable
    logic [SAMP_W-1:0] lut_q;                  // registered lookup data
    logic [SAMP_W-1:0] word, next_word;        // output word register
    logic next_strobe, strobe;
    logic vid_valid, vid_take;
    logic [SAMP_W-1:0] vid_word;
    ddswp_mode_type mode;
    assign mode = ddswp_mode_type'(mode_video_i);

    // picks line length from format
    function automatic logic [10:0] line_len(input logic f525);
        return f525 ? LINE_525 : LINE_OTHER;
    endfunction
    // picks active length from format
    function automatic logic [10:0] active_len(input logic f525);
        return f525 ? ACTIVE_525 : ACTIVE_OTHER;
    endfunction

    // ----------------------------------------
    // lookup memory, synchronous read
    // ----------------------------------------
    logic [SAMP_W-1:0] lut [DEPTH];
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            lut[wr_i.addr] <= wr_i.data;
        end
        lut_q <= lut[phase[ACC_W-1 -: ADDR_W]];
    end

    // ----------------------------------------
    // playback buffer: stalls the source when full
    // ----------------------------------------
    ddswp_fifo #(.WIDTH(SAMP_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(vid_valid_i),
        .in_ready_o(vid_ready_o),
        .in_data_i(vid_data_i),
        .out_valid_o(vid_valid),
        .out_ready_i(vid_take),
        .out_data_o(vid_word)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        // adds every clock and wraps mod 2^32, no saturation
        next_phase = phase + phase_increment_word_i;
        // 20 MHz class rate from the 40 MHz clock; carry is the enable
        {play_en, next_play_phase} = {1'b0, play_phase} + {1'b0, (format_525_i ? STEP_525 : STEP_OTHER)};
        vid_take = (mode == MODE_VIDEO) && play_en;
        next_line_cnt = line_cnt;
        next_word = word;
        next_strobe = 1'b0;
        case (mode)
            MODE_FUNC: begin
                // a sample every clock; stepped-over entries never appear
                next_word = lut_q;
                next_strobe = 1'b1;
            end
            MODE_VIDEO: begin
                if (play_en) begin
                    // underflow repeats the last word rather than glitching
                    next_word = vid_valid ? vid_word : word;
                    next_strobe = 1'b1;
                    // >= so a format switch past the shorter line length still wraps
                    next_line_cnt = (line_cnt >= line_len(format_525_i) - 11'h001) ? 11'h000
                                    : line_cnt + 11'h001;
                end
            end
            default: begin
                next_word = word;
            end
        endcase
        if (digital_sync_insert_i) begin
            // order vsync, hsync, csync, field from bit 3 down
            next_word[FLAG_W-1:0] = sync_i;
        end
    end

    // ----------------------------------------
    // registers only
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            phase <= ACC_RESET;
            play_phase <= ACC_RESET;
            line_cnt <= 11'h000;
            word <= '0;
            strobe <= 1'b0;
        end else begin
            phase <= next_phase;
            play_phase <= next_play_phase;
            line_cnt <= next_line_cnt;
            word <= next_word;
            strobe <= next_strobe;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // converter only sees the upper 12 bits, so flags leave the analog intact
    assign dac_data_o = word[SAMP_W-1 -: DAC_W];
    assign dig_data_o = word;
    assign dig_oe_o = {SAMP_W{digital_sync_insert_i}};
    assign sample_strobe_o = strobe;
    assign line_start_o = strobe && (mode == MODE_VIDEO) && (line_cnt == 11'h001);
    assign active_o = (mode == MODE_VIDEO) && (line_cnt < active_len(format_525_i));

    // ----------------------------------------
    // checks
    // ----------------------------------------
    accum_adds_word_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> phase == $past(phase) + $past(phase_increment_word_i))
        else $error("accumulator did not add increment");
    accum_wraps_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ($past(rst_n_i) && $past(phase) > phase) |-> $past(phase_increment_word_i) != '0)
        else $error("accumulator went back without increment");
    full_sweep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (phase_increment_word_i == FULL_SWEEP_WORD) ##1 (phase_increment_word_i == FULL_SWEEP_WORD)
        |-> phase[ACC_W-1 -: ADDR_W] == $past(phase[ACC_W-1 -: ADDR_W]) + 14'h0001)
        else $error("full sweep skipped an entry");
    func_every_clock_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (mode == MODE_FUNC) ##1 (mode == MODE_FUNC) |=> strobe)
        else $error("function mode missed a sample");
    func_lut_path_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (mode == MODE_FUNC && !digital_sync_insert_i) |=> word == $past(lut_q))
        else $error("output not taken from lookup");
    sync_insert_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        digital_sync_insert_i |=> word[FLAG_W-1:0] == $past(sync_i))
        else $error("sync flags not inserted");
    dig_enable_a: assert property (@(posedge clk_i)
        dig_oe_o == {SAMP_W{digital_sync_insert_i}})
        else $error("digital lines enable mismatch");
    video_half_rate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (mode == MODE_VIDEO && !format_525_i && play_en) ##1 (mode == MODE_VIDEO && !format_525_i)
        |-> !play_en)
        else $error("playback faster than half clock");
    line_wrap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (mode == MODE_VIDEO && play_en && line_cnt == line_len(format_525_i) - 11'h001)
        |=> line_cnt == 11'h000)
        else $error("line counter did not wrap at line end");
endmodule // ddswp_top
`default_nettype wire
